// file: bench/tcr_host_model.sv
/*
 * Host data channel model: grants memory breaks and keeps taken frames.
 * Assumes the bench paces it through stall_i, on the device clock.
 */
`timescale 1ns/1ps
module tcr_host_model
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Data channel from the device
    input wire logic [5:0] frame_i,
    input wire logic data_ready_flag_i,
    output logic frame_ready_o,
    // Pacing from the bench
    input wire logic stall_i
);
    logic [5:0] rx_q[$];
    // Grant moves only off the sampling edge
    always @(negedge mclk_i) frame_ready_o <= ~stall_i;
    always @(posedge mclk_i)
        if (rst_b_i && data_ready_flag_i && frame_ready_o)
            rx_q.push_back(frame_i);
endmodule

// file: bench/test_tcr_regs.sv
/*
 * Self-checking bench of the tape command registers: host instructions,
 * tape line and mark pulses, data channel through the host model.
 * Assumes tcr_pkg constants and a 50 MHz clock.
 */
`timescale 1ns/1ps
module test_tcr_regs;
    import tcr_pkg::*;
    logic mclk_i = 1'b0, rst_b_i = 1'b0, iot_strobe_i = 1'b0, frame_ready_i;
    logic [5:0] iot_dev_i = 6'h00, frame_o;
    logic [2:0] iot_code_i = 3'h7, line_data_i = 3'h0, drive_select_o;
    logic [17:0] acc_i = 18'h00000, io_data_o;
    logic io_data_valid_o, skip_o, prog_int_o, data_ready_flag_o, ca_inhibit_o;
    logic line_strobe_i = 1'b0, mark_strobe_i = 1'b0, mark_bit_i = 1'b0;
    logic select_fault_i = 1'b0, end_zone_i = 1'b0, op_complete_i = 1'b0, stall = 1'b0;
    logic counter_preset_i = 1'b0, counter_step_i = 1'b0;
    logic go_o, forward_o, continuous_mode_o, load_busy_o, sk, vd;
    logic [6:0] op_decode_o;
    int fail_count = 0, samples_checked = 0, n;
    tcr_regs dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .iot_strobe_i(iot_strobe_i),
        .iot_dev_i(iot_dev_i), .iot_code_i(iot_code_i), .acc_i(acc_i),
        .io_data_o(io_data_o), .io_data_valid_o(io_data_valid_o), .skip_o(skip_o),
        .prog_int_o(prog_int_o), .frame_o(frame_o), .data_ready_flag_o(data_ready_flag_o),
        .frame_ready_i(frame_ready_i), .ca_inhibit_o(ca_inhibit_o),
        .line_strobe_i(line_strobe_i), .line_data_i(line_data_i),
        .mark_strobe_i(mark_strobe_i), .mark_bit_i(mark_bit_i),
        .select_fault_i(select_fault_i), .end_zone_i(end_zone_i), .op_complete_i(op_complete_i),
        .counter_preset_i(counter_preset_i), .counter_step_i(counter_step_i),
        .drive_select_o(drive_select_o), .go_o(go_o), .forward_o(forward_o),
        .continuous_mode_o(continuous_mode_o), .op_decode_o(op_decode_o),
        .load_busy_o(load_busy_o));
    tcr_host_model host_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .frame_i(frame_o),
        .data_ready_flag_i(data_ready_flag_o), .frame_ready_o(frame_ready_i),
        .stall_i(stall));
    initial forever #10 mclk_i = ~mclk_i;

    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // One instruction; skip and valid pulses are caught while they stand
    task automatic io_transfer_instruction(input logic [2:0] code, input logic [17:0] acc);
        @(negedge mclk_i);
        iot_strobe_i = 1'b1;
        iot_dev_i = DEV_NUM;
        iot_code_i = code;
        acc_i = acc;
        @(negedge mclk_i);
        iot_strobe_i = 1'b0;
        sk = skip_o;
        vd = io_data_valid_o;
        repeat (3)
        begin
            @(negedge mclk_i);
            sk = sk | skip_o;
            vd = vd | io_data_valid_o;
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge mclk_i);
        s = 1'b1;
        repeat (4) @(negedge mclk_i);
        s = 1'b0;
        repeat (4) @(negedge mclk_i);
    endtask
    task automatic line(input logic [2:0] d);
        line_data_i = d;
        pulse(line_strobe_i);
    endtask
    task automatic mark(input logic b);
        mark_bit_i = b;
        pulse(mark_strobe_i);
    endtask
    // One-cycle pulse for same-clock inputs
    task automatic tick(ref logic s);
        @(negedge mclk_i);
        s = 1'b1;
        @(negedge mclk_i);
        s = 1'b0;
    endtask
    // Lead bits then a six-bit mark code, oldest bit first
    task automatic send_mark(input logic [5:0] code);
        for (int b = 8; b >= 0; b--)
            mark(b > 5 ? MK_LEAD[b - 6] : code[b]);
    endtask

    initial
    begin
        repeat (16) @(negedge mclk_i);
        rst_b_i = 1'b1;
        check("drive", drive_select_o, 3'h0);
        check("go", go_o, 1'b0);
        check("fwd", forward_o, 1'b1);
        check("int", prog_int_o, 1'b0);
        check("flag", data_ready_flag_o, 1'b0);
        io_transfer_instruction(IOT_READ_B, 18'h00000);
        check("statb", io_data_o, 18'h00000);
        io_transfer_instruction(IOT_LOAD_A, 18'h0027D);
        check("drive", drive_select_o, 3'h5);
        check("go", go_o, 1'b1);
        check("fwd", forward_o, 1'b0);
        check("mode", continuous_mode_o, 1'b1);
        check("dec", op_decode_o, 7'h02);
        check("inh", ca_inhibit_o, 1'b1);
        io_transfer_instruction(IOT_READ_A, 18'h00000);
        check("valid", vd, 1'b1);
        check("sta", io_data_o[9:0], 10'h27D);
        for (int k = 0; k < 8; k++)
        begin
            io_transfer_instruction(IOT_LOAD_A, 18'(k) << SA_OP_LSB);
            check("dec", op_decode_o, (k < 7) ? 7'(1 << k) : 7'h00);
        end
        io_transfer_instruction(IOT_LOAD_A, 18'h0027D);
        io_transfer_instruction(IOT_CLR_A, 18'h00000);
        check("busy", load_busy_o, 1'b1);
        check("drive", drive_select_o, 3'h0);
        check("fwd", forward_o, 1'b1);
        check("dec", op_decode_o, 7'h01);
        n = 0;
        while (load_busy_o === 1'b1 && n < 60)
        begin
            @(negedge mclk_i);
            n++;
        end
        check("busyend", load_busy_o, 1'b0);
        check("delay", 18'(n), 18'(LOAD_DELAY_CYC - 3));
        if (n == 60)
            tally_and_finish();
        // Selection fault while moving
        io_transfer_instruction(IOT_LOAD_A, 18'h00010);
        pulse(select_fault_i);
        check("go", go_o, 1'b0);
        pulse(op_complete_i);
        io_transfer_instruction(IOT_SKIP_ERR, 18'h00000);
        check("skiperr", sk, 1'b1);
        io_transfer_instruction(IOT_READ_B, 18'h00000);
        check("statb", io_data_o, 18'h00024);
        io_transfer_instruction(IOT_CLR_B, 18'h00000);
        // End zone while moving
        io_transfer_instruction(IOT_LOAD_A, 18'h00010);
        pulse(end_zone_i);
        check("go", go_o, 1'b0);
        io_transfer_instruction(IOT_READ_B, 18'h00000);
        check("statb", io_data_o, 18'h00028);
        io_transfer_instruction(IOT_CLR_B, 18'h00000);
        io_transfer_instruction(IOT_LOAD_A, 18'h00200);
        check("int", prog_int_o, 1'b0);
        pulse(op_complete_i);
        check("int", prog_int_o, 1'b1);
        io_transfer_instruction(IOT_SKIP_DONE, 18'h00000);
        check("skipdone", sk, 1'b1);
        io_transfer_instruction(IOT_LOAD_A, 18'h00000);
        check("int", prog_int_o, 1'b0);
        io_transfer_instruction(IOT_SKIP_DONE, 18'h00000);
        check("skipdone", sk, 1'b1);
        io_transfer_instruction(IOT_CLR_B, 18'h00000);
        io_transfer_instruction(IOT_SKIP_DONE, 18'h00000);
        check("skipdone", sk, 1'b0);
        // Search hit at counter 101 on a block number mark
        io_transfer_instruction(IOT_LOAD_A, 18'(OP_SEARCH) << SA_OP_LSB);
        tick(counter_preset_i);
        tick(counter_step_i);
        send_mark(MK_BLOCK_NUM);
        check("hit", 18'(host_u.rx_q.size()), 18'h00001);
        host_u.rx_q.delete();
        // Frames with the host stalled, third refused
        io_transfer_instruction(IOT_LOAD_A, 18'h00000);
        check("inh", ca_inhibit_o, 1'b0);
        stall = 1'b1;
        line(3'h5);
        line(3'h2);
        check("flag", data_ready_flag_o, 1'b1);
        line(3'h1);
        line(3'h6);
        line(3'h7);
        line(3'h0);
        io_transfer_instruction(IOT_READ_B, 18'h00000);
        check("timing", io_data_o[5:0], 6'h21);
        stall = 1'b0;
        n = 0;
        while (host_u.rx_q.size() < 2 && n < 50)
        begin
            @(negedge mclk_i);
            n++;
        end
        if (n == 50)
        begin
            fail_count++;
            tally_and_finish();
        end
        check("fr0", host_u.rx_q[0], 6'h2A);
        check("fr1", host_u.rx_q[1], 6'h0E);
        repeat (4) @(negedge mclk_i);
        check("drained", 18'(host_u.rx_q.size()), 18'h00002);
        check("flag", data_ready_flag_o, 1'b0);
        // Block end with bad column parity, then a block number mark out of order
        io_transfer_instruction(IOT_CLR_B, 18'h00000);
        send_mark(MK_BLOCK_END);
        mark(1'b0);
        io_transfer_instruction(IOT_READ_B, 18'h00000);
        check("marks", io_data_o, 18'h00032);
        tally_and_finish();
    end
endmodule

// file: inc/tcr_pkg.sv
/*
 * Constants of the tape control command and status registers.
 * Assumes one 50 MHz control clock; host bits numbered as printed.
 */
package tcr_pkg;
    localparam int CLK_MHZ = 50;
    // I/O transfer instruction codes
    localparam logic [2:0] IOT_CLR_A = 3'h0;
    localparam logic [2:0] IOT_LOAD_A = 3'h1;
    localparam logic [2:0] IOT_READ_A = 3'h2;
    localparam logic [2:0] IOT_READ_B = 3'h3;
    localparam logic [2:0] IOT_SKIP_DONE = 3'h4;
    localparam logic [2:0] IOT_SKIP_ERR = 3'h5;
    localparam logic [2:0] IOT_CLR_B = 3'h6;
    // Device number, value arbitrary
    localparam logic [5:0] DEV_NUM = 6'h15;
    // Status A field positions (accumulator bit numbers)
    localparam int SA_DRV_LSB = 0;
    localparam int SA_DIR_BIT = 3;
    localparam int SA_GO_BIT = 4;
    localparam int SA_MODE_BIT = 5;
    localparam int SA_OP_LSB = 6;
    localparam int SA_PERMIT_BIT = 9;
    // Status B layout
    localparam int SB_FAULT_LSB = 0;
    localparam int SB_ERRF_BIT = 5;
    localparam int SB_DONE_BIT = 6;
    // Fault bit positions
    localparam int FLT_TIMING = 0;
    localparam int FLT_PARITY = 1;
    localparam int FLT_SELECT = 2;
    localparam int FLT_END = 3;
    localparam int FLT_MARK = 4;
    // Operation codes
    localparam logic [2:0] OP_MOVE = 3'h0;
    localparam logic [2:0] OP_SEARCH = 3'h1;
    // Control counter patterns
    localparam logic [2:0] CNT_PRESET = 3'h4;
    localparam logic [2:0] CNT_SEARCH_HIT = 3'h5;
    // Mark codes in the low six window bits; lead is the tail of the previous mark
    localparam logic [5:0] MK_BLOCK_NUM = 6'h1A;
    localparam logic [5:0] MK_BLOCK_START = 6'h32;
    localparam logic [5:0] MK_BLOCK_END = 6'h0D;
    localparam logic [5:0] MK_DATA = 6'h38;
    localparam logic [2:0] MK_LEAD = 3'h5;
    localparam logic [5:0] PARITY_GOOD = 6'h3F;
    // Load delay after clear command
    localparam int LOAD_DELAY_NS = 400;
    localparam int LOAD_DELAY_CYC = (LOAD_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam logic [4:0] LOAD_DELAY_CNT = 5'(LOAD_DELAY_CYC);
    // Reset values
    localparam logic [17:0] STATUS_A_RST = 18'h00000;
    localparam logic [4:0] FAULT_RST = 5'h00;
    localparam logic [5:0] PARITY_RST = 6'h00;
    localparam logic [8:0] WINDOW_RST = 9'h000;
    localparam logic [2:0] COUNTER_RST = 3'h0;
    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_WAIT = 2'b01,
        LD_DONE = 2'b10
    } tcr_load_t;
endpackage

// file: verilog/tcr_regs.sv
/*
 * Command and status registers of a tape transport controller: host
 * instruction decode, status A/B, flags, skip and interrupt gating, column
 * parity, mark window, and a two-entry frame buffer toward the data channel.
 * Assumes host bus signals on mclk_i; tape-side inputs are asynchronous.
 */
`timescale 1ns/1ps

// Summary of operation
// - Six column parity bits flip when the matching head buffer bit is zero.
// - Mark-track bits shift serially into a nine-bit window.
// - Window holds three bits beyond a mark to check mark order.
// - Window is decoded on every shift for any legal mark code.
// - Data ready flag requests a memory break whenever a word is ready.
// - Addressed transfer instructions load status registers and raise skip requests.
// - Drive select loads from accumulator bits 0 to 2.
// - Motion loads from bits 3 and 4: direction and go.
// - One mode bit chooses normal or continuous operation.
// - Three-bit operation code is decoded and passed to the sequencer.
// - Interrupt permit loads from accumulator bit 9.
// - Five fault bits, each set independently by control logic.
// - Error flag is set when any fault bit is set.
// - Done flag sets when the selected operation completes.
// - Skip on done regardless of interrupt permit.
// - Interrupt request when error or done flag set and permit is one.
// - Clear command resets drive, motion, code, permit and starts load delay.
// - Device can inhibit the host current address increment.
// - In search, counter 101 with block number mark sets data ready.
// - Control counter can be preset to 100.
// - Non-parity faults stop the transport and suppress the done flag.
// - Head buffer is two three-bit halves shifting left per tape line.
module tcr_regs
    import tcr_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Host instruction port
    input wire logic iot_strobe_i,
    input wire logic [5:0] iot_dev_i,
    input wire logic [2:0] iot_code_i,
    input wire logic [17:0] acc_i,
    output logic [17:0] io_data_o,
    output logic io_data_valid_o,
    output logic skip_o,
    output logic prog_int_o,
    // Data channel
    output logic [5:0] frame_o,
    output logic data_ready_flag_o,
    input wire logic frame_ready_i,
    output logic ca_inhibit_o,
    // Tape side, asynchronous
    input wire logic line_strobe_i,
    input wire logic [2:0] line_data_i,
    input wire logic mark_strobe_i,
    input wire logic mark_bit_i,
    input wire logic select_fault_i,
    input wire logic end_zone_i,
    // Sequencer side, same clock
    input wire logic op_complete_i,
    input wire logic counter_preset_i,
    input wire logic counter_step_i,
    // Transport and sequencer commands
    output logic [2:0] drive_select_o,
    output logic go_o,
    output logic forward_o,
    output logic continuous_mode_o,
    output logic [6:0] op_decode_o,
    output logic load_busy_o
);
    logic [7:0] sync_a_q, sync_b_q;
    logic line_seen_q, mark_seen_q;
    logic [17:0] status_a_q, status_a_d;
    logic [4:0] fault_q;
    logic [4:0] fault_set;
    logic error_flag_q;
    logic done_q;
    logic [5:0] head_shift_buffer_q;
    logic [5:0] head_next;
    logic half_q;
    logic [5:0] column_parity_accumulator_q;
    logic [8:0] window_q;
    logic [2:0] control_counter_q;
    tcr_load_t load_q;
    logic [4:0] load_cnt_q;
    logic [5:0] out_q, skid_q;
    logic out_v_q, skid_v_q;
    logic [17:0] io_data_q;
    logic io_valid_q;
    logic skip_q;
    logic int_q;
    logic ca_inh_q;
    logic [6:0] op_dec_q;
    logic fwd_q, busy_q;

    // Synchroniser inputs
    wire [7:0] async_in = {end_zone_i, select_fault_i, mark_bit_i, mark_strobe_i,
        line_strobe_i, line_data_i};
    wire [2:0] line_data = sync_b_q[2:0];
    wire line_lvl = sync_b_q[3];
    wire mark_lvl = sync_b_q[4];
    wire mark_bit = sync_b_q[5];
    wire select_fault = sync_b_q[6];
    wire end_zone = sync_b_q[7];
    wire line_edge = line_lvl & ~line_seen_q;
    wire mark_edge = mark_lvl & ~mark_seen_q;

    // Instruction decode
    wire my_iot = iot_strobe_i & (iot_dev_i == DEV_NUM);
    wire do_clr_a = my_iot & (iot_code_i == IOT_CLR_A);
    wire do_load_a = my_iot & (iot_code_i == IOT_LOAD_A);
    wire do_read_a = my_iot & (iot_code_i == IOT_READ_A);
    wire do_read_b = my_iot & (iot_code_i == IOT_READ_B);
    wire do_skip_done = my_iot & (iot_code_i == IOT_SKIP_DONE);
    wire do_skip_err = my_iot & (iot_code_i == IOT_SKIP_ERR);
    wire do_clr_b = my_iot & (iot_code_i == IOT_CLR_B);

    // Status A fields
    wire [2:0] op_code = status_a_q[SA_OP_LSB +: 3];
    wire searching = op_code == OP_SEARCH;

    // Window decode
    wire [8:0] win_next = {window_q[7:0], mark_bit};
    wire mk_blk_num = mark_edge & (win_next[5:0] == MK_BLOCK_NUM);
    wire mk_blk_start = mark_edge & (win_next[5:0] == MK_BLOCK_START);
    wire mk_blk_end = mark_edge & (win_next[5:0] == MK_BLOCK_END);
    wire mk_data = mark_edge & (win_next[5:0] == MK_DATA);
    wire mk_legal = mk_blk_num | mk_blk_start | mk_blk_end | mk_data;
    wire mk_order_bad = mk_legal & (win_next[8:6] != MK_LEAD);

    // Frame assembly and buffer
    wire frame_done = line_edge & half_q;
    wire search_hit = searching & mk_blk_num & (control_counter_q == CNT_SEARCH_HIT);
    wire push_req = frame_done | search_hit;
    wire buf_in_ready = ~skid_v_q;
    wire push = push_req & buf_in_ready;
    wire pop = out_v_q & frame_ready_i;
    wire [5:0] push_data = frame_done ? head_next : head_shift_buffer_q;

    // Faults and flags
    wire parity_bad = mk_blk_end & (column_parity_accumulator_q != PARITY_GOOD);
    wire hard_fault = |fault_q[FLT_MARK:FLT_SELECT] | fault_q[FLT_TIMING];
    wire hard_set = fault_set[FLT_TIMING] | fault_set[FLT_SELECT] | fault_set[FLT_END]
        | fault_set[FLT_MARK];
    wire done_set = op_complete_i & ~hard_fault & ~hard_set;
    wire [4:0] fault_d = (do_clr_b ? FAULT_RST : fault_q) | fault_set;
    wire done_d = done_set | (done_q & ~do_clr_b);
    wire busy_next = do_clr_a | ((load_q == LD_WAIT) & (load_cnt_q != 5'h00));

    assign head_next = {head_shift_buffer_q[2:0], line_data};
    assign fault_set[FLT_TIMING] = push_req & ~buf_in_ready;
    assign fault_set[FLT_PARITY] = parity_bad;
    assign fault_set[FLT_SELECT] = select_fault;
    assign fault_set[FLT_END] = end_zone & go_o;
    assign fault_set[FLT_MARK] = mk_order_bad;

    always_comb
    begin
        status_a_d = status_a_q;
        if (do_clr_a)
            status_a_d = STATUS_A_RST;
        else if (do_load_a)
            status_a_d = acc_i;
        if (hard_set)
            status_a_d[SA_GO_BIT] = 1'b0;
    end

    // Synchroniser, two stages, then a seen stage for edges
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sync_a_q <= 8'h00;
            sync_b_q <= 8'h00;
            line_seen_q <= 1'b0;
            mark_seen_q <= 1'b0;
        end
        else
        begin
            sync_a_q <= async_in;
            sync_b_q <= sync_a_q;
            line_seen_q <= line_lvl;
            mark_seen_q <= mark_lvl;
        end
    end

    // Status A, fault bits and flags
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            status_a_q <= STATUS_A_RST;
            fault_q <= FAULT_RST;
            error_flag_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            status_a_q <= status_a_d;
            fault_q <= fault_d;
            error_flag_q <= |fault_d;
            done_q <= done_d;
        end
    end

    // Head buffer and column parity
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            head_shift_buffer_q <= 6'h00;
            half_q <= 1'b0;
        end
        else if (line_edge && (buf_in_ready || !half_q))
        begin
            head_shift_buffer_q <= head_next;
            half_q <= ~half_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_par
            always_ff @(posedge mclk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    column_parity_accumulator_q[gi] <= 1'b0;
                else if (mk_blk_start)
                    column_parity_accumulator_q[gi] <= 1'b0;
                else if (frame_done && buf_in_ready && !head_next[gi])
                    column_parity_accumulator_q[gi] <= ~column_parity_accumulator_q[gi];
            end
        end
        for (gi = 0; gi < 7; gi++)
        begin : g_dec
            always_ff @(posedge mclk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    op_dec_q[gi] <= 1'b0;
                else
                    op_dec_q[gi] <= op_code == 3'(gi);
            end
        end
    endgenerate

    // Mark window and control counter
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            window_q <= WINDOW_RST;
            control_counter_q <= COUNTER_RST;
        end
        else
        begin
            if (mark_edge)
                window_q <= win_next;
            if (counter_preset_i)
                control_counter_q <= CNT_PRESET;
            else if (counter_step_i)
                control_counter_q <= control_counter_q + 3'h1;
        end
    end

    // Load delay after clear command
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            load_q <= LD_IDLE;
            load_cnt_q <= 5'h00;
        end
        else if (do_clr_a)
        begin
            load_q <= LD_WAIT;
            load_cnt_q <= LOAD_DELAY_CNT - 5'h01;
        end
        else
        begin
            case (load_q)
                LD_IDLE:
                    load_q <= LD_IDLE;
                LD_WAIT:
                begin
                    if (load_cnt_q == 5'h00)
                        load_q <= LD_DONE;
                    else
                        load_cnt_q <= load_cnt_q - 5'h01;
                end
                LD_DONE:
                    load_q <= LD_IDLE;
                default:
                    load_q <= LD_IDLE;
            endcase
        end
    end

    // Two-entry frame buffer: output register plus skid
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            out_q <= 6'h00;
            out_v_q <= 1'b0;
            skid_q <= 6'h00;
            skid_v_q <= 1'b0;
        end
        else
        begin
            if (!out_v_q || pop)
            begin
                out_v_q <= skid_v_q | push;
                out_q <= skid_v_q ? skid_q : push_data;
                skid_v_q <= skid_v_q & push;
                skid_q <= push_data;
            end
            else if (push)
            begin
                skid_v_q <= 1'b1;
                skid_q <= push_data;
            end
        end
    end

    // Host answers
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            io_data_q <= 18'h00000;
            io_valid_q <= 1'b0;
            skip_q <= 1'b0;
            int_q <= 1'b0;
            ca_inh_q <= 1'b0;
            fwd_q <= 1'b1;
            busy_q <= 1'b0;
        end
        else
        begin
            io_valid_q <= do_read_a | do_read_b;
            if (do_read_a)
                io_data_q <= status_a_q;
            else if (do_read_b)
                io_data_q <= {11'h000, done_q, error_flag_q, fault_q};
            skip_q <= (do_skip_done & done_q) | (do_skip_err & error_flag_q);
            int_q <= status_a_q[SA_PERMIT_BIT] & (error_flag_q | done_q);
            ca_inh_q <= searching;
            fwd_q <= ~status_a_d[SA_DIR_BIT];
            busy_q <= busy_next;
        end
    end

    assign io_data_o = io_data_q;
    assign io_data_valid_o = io_valid_q;
    assign skip_o = skip_q;
    assign prog_int_o = int_q;
    assign frame_o = out_q;
    assign data_ready_flag_o = out_v_q;
    assign ca_inhibit_o = ca_inh_q;
    assign drive_select_o = status_a_q[SA_DRV_LSB +: 3];
    assign go_o = status_a_q[SA_GO_BIT];
    assign forward_o = fwd_q;
    assign continuous_mode_o = status_a_q[SA_MODE_BIT];
    assign op_decode_o = op_dec_q;
    assign load_busy_o = busy_q;

    // Checks
    chk_skip_done_gate: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        do_skip_done && done_q |=> skip_o)
        else $error("skip missing with done flag set");
    chk_int_gate: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        prog_int_o |-> $past(status_a_q[SA_PERMIT_BIT]))
        else $error("interrupt without permit");
    chk_err_flag: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        fault_set != 5'h00 |=> error_flag_q && fault_q != 5'h00)
        else $error("error flag missing after fault");
    chk_clear_cmd: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        do_clr_a |=> drive_select_o == 3'h0 && !go_o && load_busy_o)
        else $error("clear command did not reset status");
    chk_load_drive: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        do_load_a && !hard_set |=> drive_select_o == $past(acc_i[2:0])
        && go_o == $past(acc_i[4]))
        else $error("status load wrong");
    chk_hard_stop: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        hard_set |=> !go_o && !$rose(done_q))
        else $error("hard fault did not stop transport");
    chk_preset_cnt: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        counter_preset_i |=> control_counter_q == CNT_PRESET)
        else $error("counter preset wrong");
    chk_window_shift: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        mark_edge |=> window_q[0] == $past(mark_bit) && window_q[8:1] == $past(window_q[7:0]))
        else $error("window shift wrong");
    chk_search_ready: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        search_hit && !out_v_q |=> data_ready_flag_o)
        else $error("search hit lost");
    chk_parity_flip: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        frame_done && buf_in_ready && !mk_blk_start |=> column_parity_accumulator_q
        == ($past(column_parity_accumulator_q) ^ ~$past(head_next)))
        else $error("parity accumulate wrong");
    cov_search_hit: cover property (@(posedge mclk_i) disable iff (!rst_b_i) search_hit);
    cov_buf_full: cover property (@(posedge mclk_i) disable iff (!rst_b_i) skid_v_q && !pop);
    cov_int: cover property (@(posedge mclk_i) disable iff (!rst_b_i) $rose(prog_int_o));
endmodule
